// File: verilog/timer_unit.sv
// Design decisions made here: the APB interface to the registers and the placing of the registers.
module timer_unit (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rstn,
  // APB slave
  input  wire timer_pkg::apb_req_t   apb_req,
  output timer_pkg::apb_rsp_t        apb_rsp,
  // Slow oscillator pin, asynchronous
  input  wire logic                  slow_oscillator,
  // Start and stop events from the protocol logic, same clock
  input  wire logic [timer_pkg::NT-1:0] start_event,
  input  wire logic [timer_pkg::NT-1:0] stop_event,
  // Card detection result, same clock
  input  wire logic                  card_check_done,
  input  wire logic                  card_present,
  // Outputs
  output logic                       irq,
  output logic                       standby
);

  timer_pkg::state_t s_r;
  timer_pkg::state_t s_nxt;

  logic [timer_pkg::NT-1:0] uf;
  logic [timer_pkg::NT-1:0] tk;
  logic [timer_pkg::NT-1:0] start_req;
  logic [timer_pkg::NT-1:0] stop_req;
  logic                     fast_tk;
  logic                     slow_tk;
  logic                     lfo_tk;
  logic [18:0]              sum_fast;
  logic [18:0]              sum_slow;
  logic                     wr;
  logic                     setup;
  logic [7:0]               addr;
  logic [31:0]              wd;
  logic [2:0]               blk;
  logic [2:0]               ti;
  logic                     tmr_hit;
  logic                     hit;
  logic [31:0]              rdval;
  logic [4:0]               act_old;
  logic [4:0]               act_new;

  assign apb_rsp = s_r.rsp;
  assign irq     = s_r.irq;
  assign standby = s_r.standby;

  always_comb begin
    s_nxt     = s_r;
    uf        = '0;
    tk        = '0;
    start_req = '0;
    stop_req  = '0;
    rdval     = 32'h0000_0000;
    addr      = apb_req.paddr;
    wd        = apb_req.pwdata;
    setup     = apb_req.psel & ~apb_req.penable;
    wr        = apb_req.psel & apb_req.penable & apb_req.pwrite
                & s_r.rsp.pready;

    //////////////////////////////////////////////////////////////////////////
    // Rate enables: fractional dividers keep the average rate exact
    sum_fast = {1'b0, s_r.acc_fast} + {1'b0, timer_pkg::FAST_KHZ};
    fast_tk  = sum_fast >= {1'b0, timer_pkg::CLK_KHZ};
    s_nxt.acc_fast = fast_tk ? 18'(sum_fast - {1'b0, timer_pkg::CLK_KHZ})
                             : sum_fast[17:0];
    sum_slow = {1'b0, s_r.acc_slow} + {1'b0, timer_pkg::SLOW_KHZ};
    slow_tk  = sum_slow >= {1'b0, timer_pkg::CLK_KHZ};
    s_nxt.acc_slow = slow_tk ? 18'(sum_slow - {1'b0, timer_pkg::CLK_KHZ})
                             : sum_slow[17:0];

    // Slow oscillator edge; stage three is compared with stage two and with lfo_stable
    s_nxt.lfo_sync = {s_r.lfo_sync[1:0], slow_oscillator};
    lfo_tk = 1'b0;
    if (s_r.lfo_sync[1] == s_r.lfo_sync[2] &&
        s_r.lfo_sync[2] != s_r.lfo_stable) begin
      s_nxt.lfo_stable = s_r.lfo_sync[2];
      lfo_tk = s_r.lfo_sync[2];
    end

    //////////////////////////////////////////////////////////////////////////
    // Address decode
    blk     = addr[6:4];
    ti      = 3'(blk - 3'h1);
    tmr_hit = ~addr[7] && blk != 3'h0 && blk <= 3'h5 && addr[1:0] == 2'h0
              && addr[3:0] <= timer_pkg::COUNT_OFF;
    hit     = tmr_hit || addr == timer_pkg::CTRL_OFF ||
              addr == timer_pkg::FLAG_OFF || addr == timer_pkg::ENA_OFF ||
              addr == timer_pkg::STAT_OFF;

    // Read data is captured in the setup cycle so pready can be a flop
    if (tmr_hit) begin
      case (addr[3:0])
        timer_pkg::MODE_OFF:   rdval = {24'h0, s_r.mode[ti]};
        timer_pkg::RELOAD_OFF: rdval = {16'h0, s_r.reload[ti]};
        default:               rdval = {16'h0, s_r.count[ti]};
      endcase
    end else begin
      case (addr)
        timer_pkg::CTRL_OFF: begin
          for (int i = 0; i < timer_pkg::NGEN; i++) begin
            rdval[i] = s_r.tst[i] != timer_pkg::T_IDLE;
          end
        end
        timer_pkg::FLAG_OFF: rdval = {25'h0, s_r.flags};
        timer_pkg::ENA_OFF:  rdval = {25'h0, s_r.ena};
        timer_pkg::STAT_OFF: begin
          rdval[timer_pkg::SB_ANY]     = s_r.flags[timer_pkg::FB_ANY];
          rdval[timer_pkg::SB_STANDBY] = s_r.standby;
        end
        default: rdval = 32'h0000_0000;
      endcase
    end
    s_nxt.rsp.pready  = setup;
    s_nxt.rsp.pslverr = setup & ~hit;
    if (setup) begin
      s_nxt.rsp.prdata = rdval;
    end

    //////////////////////////////////////////////////////////////////////////
    // Register writes
    if (wr && tmr_hit) begin
      case (addr[3:0])
        timer_pkg::MODE_OFF: begin
          s_nxt.mode[ti] = wd[7:0] & timer_pkg::MODE_KEEP;
          start_req[ti] = wd[timer_pkg::MB_START];
          stop_req[ti]  = wd[timer_pkg::MB_STOP];
        end
        timer_pkg::RELOAD_OFF: s_nxt.reload[ti] = wd[15:0];
        default: ;
      endcase
    end else if (wr) begin
      case (addr)
        timer_pkg::CTRL_OFF: begin
          for (int i = 0; i < timer_pkg::NGEN; i++) begin
            if (wd[timer_pkg::NGEN+i]) begin
              start_req[i] = wd[i];
              stop_req[i]  = ~wd[i];
            end
          end
        end
        timer_pkg::FLAG_OFF: begin
          if (wd[timer_pkg::FB_SETCLR]) begin
            s_nxt.flags = s_r.flags | wd[6:0];
          end else begin
            s_nxt.flags = s_r.flags & ~wd[6:0];
          end
        end
        timer_pkg::ENA_OFF: begin
          s_nxt.ena = wd[timer_pkg::FB_SETCLR] ? s_r.ena | wd[6:0]
                                                : s_r.ena & ~wd[6:0];
        end
        timer_pkg::STAT_OFF: begin
          if (wd[timer_pkg::SB_STANDBY]) begin
            s_nxt.standby = 1'b1;
          end
        end
        default: ;
      endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // Timers; the wake-up timer goes first so its underflow can clock others
    for (int i = timer_pkg::NT - 1; i >= 0; i--) begin
      if (i == timer_pkg::WAKE) begin
        tk[i] = lfo_tk;
      end else begin
        case (s_r.mode[i][timer_pkg::MB_SEL +: 2])
          timer_pkg::SEL_FAST: tk[i] = fast_tk;
          timer_pkg::SEL_SLOW: tk[i] = slow_tk;
          timer_pkg::SEL_WAKE: tk[i] = uf[timer_pkg::WAKE];
          default:             tk[i] = 1'b0;
        endcase
      end
      if (stop_req[i]) begin
        s_nxt.tst[i] = timer_pkg::T_IDLE;
      end else if (start_req[i]) begin
        s_nxt.count[i] = s_nxt.reload[i];
        // A mode write that also starts must use its own wait bit
        s_nxt.tst[i] = s_nxt.mode[i][timer_pkg::MB_WAIT] ?
                       timer_pkg::T_ARMED : timer_pkg::T_COUNT;
      end else begin
        case (s_r.tst[i])
          timer_pkg::T_IDLE: ;
          timer_pkg::T_ARMED: begin
            if (start_event[i]) begin
              s_nxt.tst[i] = timer_pkg::T_COUNT;
            end
          end
          timer_pkg::T_COUNT: begin
            if (s_r.mode[i][timer_pkg::MB_STOPEV] && stop_event[i]) begin
              // Count is kept so the host can read elapsed time
              s_nxt.tst[i] = timer_pkg::T_IDLE;
            end else if (tk[i]) begin
              if (s_r.count[i] == 16'h0000) begin
                uf[i] = 1'b1;
                if (s_r.mode[i][timer_pkg::MB_AUTO]) begin
                  s_nxt.count[i] = s_nxt.reload[i];
                end else begin
                  s_nxt.tst[i] = timer_pkg::T_IDLE;
                end
              end else begin
                s_nxt.count[i] = 16'(s_r.count[i] - 16'h0001);
              end
            end
          end
          default: s_nxt.tst[i] = timer_pkg::T_IDLE;
        endcase
      end
      // Hardware set wins over a host clear in the same cycle
      if (uf[i]) begin
        s_nxt.flags[i] = 1'b1;
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // Any-source flag and interrupt pin
    act_old = s_r.flags[4:0] & s_r.ena[4:0];
    act_new = s_nxt.flags[4:0] & s_nxt.ena[4:0];
    if (|(act_new & ~act_old)) begin
      s_nxt.flags[timer_pkg::FB_ANY] = 1'b1;
    end
    s_nxt.irq = s_nxt.ena[timer_pkg::EB_PIN] & (|act_new);

    //////////////////////////////////////////////////////////////////////////
    // Standby control
    if (uf[timer_pkg::WAKE]) begin
      s_nxt.standby = 1'b0;
    end else if (card_check_done && !card_present &&
                 s_r.mode[timer_pkg::WAKE][timer_pkg::MB_WAKE]) begin
      s_nxt.standby = 1'b1;
    end
    // Without auto-wake a card miss does not re-enter standby; only a host write to STAT_OFF does
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

// File: verilog/timer_pkg.sv
package timer_pkg;

  localparam int NT   = 5;
  localparam int WAKE = 4;
  localparam int NGEN = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses)
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] FLAG_OFF   = 8'h04;
  localparam logic [7:0] ENA_OFF    = 8'h08;
  localparam logic [7:0] STAT_OFF   = 8'h0C;
  // Per timer block at 0x10 * (index + 1)
  localparam logic [3:0] MODE_OFF   = 4'h0;
  localparam logic [3:0] RELOAD_OFF = 4'h4;
  localparam logic [3:0] COUNT_OFF  = 4'h8;

  // Mode register fields
  localparam int MB_SEL    = 0;
  localparam int MB_AUTO   = 2;
  localparam int MB_START  = 3;
  localparam int MB_WAIT   = 4;
  localparam int MB_STOPEV = 5;
  localparam int MB_WAKE   = 6;
  localparam int MB_STOP   = 7;
  localparam logic [7:0] MODE_KEEP = 8'h77;

  localparam logic [1:0] SEL_FAST = 2'h0;
  localparam logic [1:0] SEL_SLOW = 2'h1;
  localparam logic [1:0] SEL_WAKE = 2'h2;

  // Flag / enable fields
  localparam int FB_ANY    = 6;
  localparam int FB_SETCLR = 7;
  localparam int EB_PIN    = 6;
  // Status fields
  localparam int SB_ANY     = 0;
  localparam int SB_STANDBY = 1;

  // Reset values
  localparam logic [7:0]  RST_MODE   = 8'h00;
  localparam logic [15:0] RST_RELOAD = 16'h0000;
  localparam logic [6:0]  RST_FLAGS  = 7'h00;

  // Rate generation in kHz, phase accumulator style
  localparam logic [17:0] CLK_KHZ  = 18'h1E848;
  localparam logic [17:0] FAST_KHZ = 18'h034F8;
  localparam logic [17:0] SLOW_KHZ = 18'h000D4;

  typedef enum logic [1:0] {T_IDLE, T_ARMED, T_COUNT} tmr_state_t;

  typedef struct packed {
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  typedef struct packed {
    tmr_state_t [NT-1:0] tst;
    logic [NT-1:0][15:0] count;
    logic [NT-1:0][15:0] reload;
    logic [NT-1:0][7:0]  mode;
    logic [6:0]          flags;
    logic [6:0]          ena;
    logic [2:0]          lfo_sync;
    logic                lfo_stable;
    logic [17:0]         acc_fast;
    logic [17:0]         acc_slow;
    apb_rsp_t            rsp;
    logic                irq;
    logic                standby;
  } state_t;

endpackage

// File: tb/timer_unit_sva.sv
module timer_unit_sva (
  // Clock and reset
  input wire logic                clk,
  input wire logic                rstn,
  // Bus
  input wire timer_pkg::apb_req_t apb_req,
  input wire timer_pkg::apb_rsp_t apb_rsp,
  // Card check and outputs
  input wire logic                card_check_done,
  input wire logic                card_present,
  input wire logic                irq,
  input wire logic                standby
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pin_r;
  logic acc;
  logic wr;
  logic rd;
  assign acc = apb_req.psel && apb_req.penable && apb_rsp.pready;
  assign wr = acc && apb_req.pwrite;
  assign rd = acc && !apb_req.pwrite;
  // Shadow of the pin enable, so the pin is tied to its cause
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      pin_r <= 1'b0;
    else if (wr && apb_req.paddr == timer_pkg::ENA_OFF && apb_req.pwdata[6])
      pin_r <= apb_req.pwdata[7];
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_rdy_after_setup: assert property (
    apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
    else $error("no ready after setup");
  a_rdy_one_cycle: assert property (
    apb_rsp.pready |=> !apb_rsp.pready) else $error("ready too long");
  a_rdy_in_access: assert property (
    apb_rsp.pready |-> apb_req.psel && apb_req.penable)
    else $error("ready outside access");
  a_err_reads_zero: assert property (
    apb_rsp.pready && apb_rsp.pslverr |-> apb_rsp.prdata == 32'h0)
    else $error("error with data");
  a_ctrl_bits: assert property (
    rd && apb_req.paddr == timer_pkg::CTRL_OFF |-> apb_rsp.prdata[31:4] == 0)
    else $error("control upper bits set");
  a_count_width: assert property (
    rd && apb_req.paddr[3:0] == timer_pkg::COUNT_OFF
    && apb_req.paddr[7:4] inside {[1:5]} |-> apb_rsp.prdata[31:16] == 0)
    else $error("count wider than 16 bits");
  // Pin enable and irq are registered on the same edge
  a_pin_gated: assert property (!pin_r |-> !irq)
    else $error("irq without pin enable");
  a_standby_cause: assert property ($rose(standby) |->
    $past(card_check_done && !card_present) || $past(wr
    && apb_req.paddr == timer_pkg::STAT_OFF && apb_req.pwdata[1]))
    else $error("standby without cause");
endmodule

bind timer_unit timer_unit_sva u_sva (.clk(clk), .rstn(rstn),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .card_check_done(card_check_done),
  .card_present(card_present), .irq(irq), .standby(standby));

// File: tb/timer_unit_tb.sv
module timer_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CT = timer_pkg::CTRL_OFF;
  localparam logic [7:0] FL = timer_pkg::FLAG_OFF;
  localparam logic [7:0] EN = timer_pkg::ENA_OFF;
  logic                clk = 0;
  logic                rstn = 0;
  logic                osc = 0;
  logic                done_p = 0;
  logic                present = 0;
  logic [4:0]          start_ev = 0;
  logic [4:0]          stop_ev = 0;
  logic [3:0]          oc = 0;
  logic                irq;
  logic                standby;
  timer_pkg::apb_req_t req = '0;
  timer_pkg::apb_rsp_t rsp;
  logic [31:0]         rd;
  logic                slverr;
  logic [15:0]         r;
  logic [15:0]         c;
  int                  errors = 0;
  int                  n_compared = 0;

  timer_unit dut (.clk(clk), .rstn(rstn), .apb_req(req), .apb_rsp(rsp),
    .slow_oscillator(osc), .start_event(start_ev), .stop_event(stop_ev),
    .card_check_done(done_p), .card_present(present), .irq(irq),
    .standby(standby));

  always #4 clk = ~clk;
  // Slow clock runs free, well below the fast tick rate
  always @(posedge clk) begin
    oc <= oc + 4'h1;
    osc <= oc[3];
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] ta(input int i, input logic [7:0] o);
    return 8'(16 * (i + 1)) | o;
  endfunction
  task automatic ck(input string s, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    // One idle edge first, so psel is never assigned twice in a step
    @(posedge clk);
    req <= '{a, 1'b1, 1'b0, w, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    rd = rsp.prdata;
    slverr = rsp.pslverr;
    if (n >= 20) ck("pready", 1, 0);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic rc(string s, logic [7:0] a, logic [31:0] e, logic [31:0] m);
    bus(0, a, 0);
    ck(s, e, rd & m);
  endtask
  task automatic waitf(input int b, input int lim);
    int k = 0;
    do begin
      bus(0, FL, 0);
      k++;
    end while (rd[b] !== 1'b1 && k < lim);
    ck("flag", 1, rd[b]);
  endtask
  task automatic card(input logic p, input logic e);
    @(posedge clk);
    present <= p;
    done_p <= 1'b1;
    @(posedge clk);
    done_p <= 1'b0;
    @(negedge clk);
    ck("standby", e, standby);
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    final_report();
  end

  initial begin
    void'($urandom(83614));
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rc("mode", ta(0, 8'h0), 0, 32'hFF);
    rc("reload", ta(2, 8'h4), 0, 32'hFFFFFFFF);
    rc("flags", FL, 0, 32'hFF);
    bus(1, 8'hF0, 32'hFF);
    ck("unmapped", 1, slverr);
    $display("test reset done");
    r = 16'($urandom_range(3, 12));
    bus(1, ta(0, 8'h4), {16'h0, r});
    bus(1, EN, 32'hC1);
    bus(1, CT, 32'h11);
    rc("run", CT, 1, 32'h1);
    bus(0, ta(0, 8'h8), 0);
    ck("first", 1, rd[15:0] == r || rd[15:0] == r - 1);
    waitf(0, 80);
    rc("halt", ta(0, 8'h8), 0, 32'hFFFF);
    rc("run off", CT, 0, 32'h1);
    rc("any", timer_pkg::STAT_OFF, 1, 32'h1);
    ck("irq", 1, irq);
    bus(1, FL, 32'h7F);
    rc("clear", FL, 0, 32'h7F);
    bus(1, FL, 32'h84);
    rc("host set", FL, 32'h04, 32'h7F);
    repeat (2) @(negedge clk);
    ck("gated", 0, irq);
    bus(1, EN, 32'h84);
    repeat (2) @(negedge clk);
    ck("irq on", 1, irq);
    bus(1, FL, 32'h7F);
    bus(1, EN, 32'h04);
    $display("test oneshot done");
    r = 16'($urandom_range(3, 12));
    bus(1, ta(1, 8'h4), {16'h0, r});
    bus(1, ta(1, 8'h0), 32'h0C);
    waitf(1, 80);
    bus(1, FL, 32'h02);
    waitf(1, 80);
    bus(1, CT, 32'h20);
    rc("run1 off", CT, 0, 32'h2);
    bus(0, ta(1, 8'h8), 0);
    c = rd[15:0];
    rc("stopped", ta(1, 8'h8), {16'h0, c}, 32'hFFFF);
    $display("test periodic done");
    r = 16'($urandom_range(150, 250));
    bus(1, ta(2, 8'h4), {16'h0, r});
    bus(1, ta(2, 8'h0), 32'h30);
    bus(1, CT, 32'h44);
    repeat (40) @(posedge clk);
    rc("armed", ta(2, 8'h8), {16'h0, r}, 32'hFFFF);
    rc("armed run", CT, 32'h4, 32'h4);
    start_ev <= 5'h04;
    @(posedge clk);
    start_ev <= 5'h00;
    repeat ($urandom_range(30, 60)) @(posedge clk);
    stop_ev <= 5'h04;
    @(posedge clk);
    stop_ev <= 5'h00;
    bus(0, ta(2, 8'h8), 0);
    c = rd[15:0];
    ck("moved", 1, c < r);
    repeat (40) @(posedge clk);
    rc("kept", ta(2, 8'h8), {16'h0, c}, 32'hFFFF);
    rc("no flag", FL, 0, 32'h04);
    $display("test timeout done");
    bus(1, ta(3, 8'h4), 32'h1);
    bus(1, ta(3, 8'h0), 32'h09);
    repeat (200) @(posedge clk);
    rc("slow early", FL, 0, 32'h08);
    waitf(3, 1000);
    $display("test slow done");
    bus(1, ta(4, 8'h4), 32'h2);
    bus(1, ta(0, 8'h4), 32'h1);
    bus(1, FL, 32'h7F);
    bus(1, ta(0, 8'h0), 32'h0A);
    bus(1, ta(4, 8'h0), 32'h4C);
    bus(1, timer_pkg::STAT_OFF, 32'h02);
    @(negedge clk);
    ck("standby in", 1, standby);
    waitf(4, 60);
    @(negedge clk);
    ck("woken", 0, standby);
    // Wake-up timer halted so no underflow races the card result
    bus(1, ta(4, 8'h0), 32'hC4);
    card(1, 0);
    card(0, 1);
    bus(1, ta(4, 8'h0), 32'h4C);
    waitf(0, 100);
    bus(1, ta(4, 8'h0), 32'h04);
    bus(1, FL, 32'h10);
    waitf(4, 60);
    @(negedge clk);
    ck("woken again", 0, standby);
    card(0, 0);
    $display("test wakeup done");
    final_report();
  end
endmodule
